// file: core/swr_pkg.sv
package swr_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ                 = 10_000_000;
  localparam int unsigned CLK_NS                 = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RESET_LOW_TIME_US      = 480;
  localparam int unsigned RESET_DETECT_CYC       = (RESET_LOW_TIME_US * 1000 + CLK_NS - 1)
                                                   / CLK_NS;
  localparam int unsigned PRESENCE_WAIT_TIME_US  = 30;
  localparam int unsigned PRESENCE_WAIT_CYC      = (PRESENCE_WAIT_TIME_US * 1000) / CLK_NS;
  localparam int unsigned PRESENCE_LOW_TIME_US   = 120;
  localparam int unsigned PRESENCE_LOW_CYC       = (PRESENCE_LOW_TIME_US * 1000) / CLK_NS;
  localparam int unsigned SLOT_SAMPLE_TIME_US    = 30;
  localparam int unsigned SLOT_SAMPLE_CYC        = (SLOT_SAMPLE_TIME_US * 1000) / CLK_NS;
  localparam int unsigned IDLE_LOW_TIME_US       = 120;
  localparam int unsigned IDLE_LOW_CYC           = (IDLE_LOW_TIME_US * 1000) / CLK_NS;
  localparam int unsigned TMR_W                  = 13;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [7:0] CMD_READ_ROM    = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM   = 8'h55;
  localparam logic [7:0] CMD_SKIP_ROM    = 8'hCC;
  localparam logic [7:0] CMD_SEARCH_ROM  = 8'hF0;
  localparam logic [7:0] CMD_WRITE_APP   = 8'h99;
  localparam logic [7:0] CMD_READ_STATUS = 8'h66;
  localparam logic [7:0] CMD_READ_APP    = 8'hC3;
  localparam logic [7:0] CMD_COPY_LOCK   = 8'h5A;
  localparam logic [7:0] KEY_STATUS      = 8'h00;
  localparam logic [7:0] KEY_COPY_LOCK   = 8'hA5;

  // ==========================================================================
  // Status byte and register layout
  // ==========================================================================
  localparam logic [7:0] STATUS_UNLOCKED = 8'hFF;
  localparam logic [7:0] STATUS_LOCKED   = 8'hFC;
  localparam logic [2:0] ADDR_LAST       = 3'h7;
  localparam int unsigned APP_BYTES      = 8;
  localparam int unsigned FIFO_DEPTH     = 32;
  localparam int unsigned FIFO_WIDTH     = 8;

  typedef enum logic [10:0] {
    ST_IDLE    = 11'h001,
    ST_ROM_CMD = 11'h002,
    ST_ROM_TX  = 11'h004,
    ST_MATCH   = 11'h008,
    ST_SEARCH  = 11'h010,
    ST_MEM_CMD = 11'h020,
    ST_ADDR    = 11'h040,
    ST_WR_DATA = 11'h080,
    ST_RD_DATA = 11'h100,
    ST_KEY     = 11'h200,
    ST_WAIT    = 11'h400
  } swr_state_t;

  typedef enum logic [1:0] {
    SR_BIT  = 2'h0,
    SR_COMP = 2'h1,
    SR_PICK = 2'h2
  } swr_srch_t;

  typedef struct packed {
    logic       rst_pulse;
    logic       slot;
    logic       sampled;
  } swr_slot_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } swr_wr_t;

endpackage

// file: core/swr_fifo.sv
module swr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             flush_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i || flush_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule

// file: core/swr_line.sv
module swr_line
  import swr_pkg::*;
(
  input  wire logic      clock_i,
  input  wire logic      reset_i,
  input  wire logic      line_i,
  input  wire logic      send_zero_i,
  output swr_pkg::swr_slot_t ev_o,
  output logic           line_oe_n_o,
  output logic           line_o,
  output logic           idle_low_o
);
  logic                  prev_q;
  logic [TMR_W-1:0]      low_q;
  logic [TMR_W-1:0]      tmr_q;
  logic                  slot_q;
  logic                  drive_q;
  logic                  pres_q;
  logic                  pwait_q;
  swr_slot_t             ev_q;
  logic                  fall;
  logic                  rise;

  assign fall        = prev_q && !line_i;
  assign rise        = !prev_q && line_i;
  assign line_o      = 1'b0;
  assign line_oe_n_o = !(drive_q || pres_q);
  assign ev_o        = ev_q;
  assign idle_low_o  = (low_q >= TMR_W'(IDLE_LOW_CYC));

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prev_q <= 1'b1;
      low_q  <= '0;
    end else begin
      prev_q <= line_i;
      if (line_i) begin
        low_q <= '0;
      end else if (low_q != '1) begin
        low_q <= low_q + 1'b1;
      end
    end
  end

  // Slot timing, sampling and presence
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tmr_q   <= '0;
      slot_q  <= 1'b0;
      drive_q <= 1'b0;
      pres_q  <= 1'b0;
      pwait_q <= 1'b0;
      ev_q    <= '0;
    end else begin
      ev_q <= '0;
      if (rise && low_q >= TMR_W'(RESET_DETECT_CYC)) begin
        ev_q.rst_pulse <= 1'b1;
        pwait_q        <= 1'b1;
        slot_q         <= 1'b0;
        drive_q        <= 1'b0;
        tmr_q          <= '0;
      end else if (pwait_q) begin
        tmr_q <= tmr_q + 1'b1;
        if (tmr_q == TMR_W'(PRESENCE_WAIT_CYC - 1)) begin
          pwait_q <= 1'b0;
          pres_q  <= 1'b1;
          tmr_q   <= '0;
        end
      end else if (pres_q) begin
        tmr_q <= tmr_q + 1'b1;
        if (tmr_q == TMR_W'(PRESENCE_LOW_CYC - 1)) begin
          pres_q <= 1'b0;
        end
      end else if (fall && !slot_q) begin
        slot_q  <= 1'b1;
        drive_q <= send_zero_i;
        tmr_q   <= '0;
      end else if (slot_q) begin
        tmr_q <= tmr_q + 1'b1;
        if (tmr_q == TMR_W'(SLOT_SAMPLE_CYC - 1)) begin
          slot_q       <= 1'b0;
          drive_q      <= 1'b0;
          ev_q.slot    <= 1'b1;
          ev_q.sampled <= line_i;
        end
      end
    end
  end

endmodule

// file: core/swr_slave.sv
// Functional notes
// - Write-app command takes a start address, then bytes stored with address increment.
// - Write address wraps from 07h to 00h; bytes accepted until reset pulse.
// - When locked, write sequence is accepted but its data is discarded.
// - Status read needs validation byte 00h before the status byte is sent.
// - Status byte has its two low bits cleared when locked, others one.
// - A reset pulse ends a status read at any time.
// - Read-app returns scratchpad while unlocked, application register once locked.
// - Read-app takes a start address, increments and wraps 07h to 00h.
// - Copy-and-lock with key A5h copies the scratchpad and write-protects it.
// - A reset pulse instead of the key cancels copy-and-lock.
// - Copy-and-lock runs once; later writes to the register are refused.
// - Line idles high; low longer than 120 us resets the device.
// - Reset, presence, ROM command, memory command, then data, in order.
// - Read-ROM sends family code, serial number, then CRC.
// - Match-ROM compares 64 bits; only an exact match goes on.
// - Skip-ROM goes straight to the memory command.
// - Search sends bit and complement, then stays only if master bit matches.
// - Presence waits after reset rise, then drives the line low.
// - Every slot starts on the master falling edge; write slots sampled later.
// - Read slot zero holds the line low; a one leaves it alone.
// - All bytes travel least significant bit first.
// - Status reads FCh once locked and FFh before.
module swr_slave
  import swr_pkg::*;
#(
  parameter logic [63:0] ROM_ID = 64'h0000_0000_0000_0001 // Arbitrary identity value
) (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       line_i,
  output logic            line_o,
  output logic            line_oe_n_o,
  output logic            locked_o,
  output logic      [7:0] lock_status_byte_o,
  output logic     [63:0] app_reg_o
);
  // ==========================================================================
  // Line front end and write-data buffer
  // ==========================================================================
  swr_slot_t       ev;
  logic            idle_low;
  logic            send_zero;
  logic            bus_rst;

  swr_state_t      st_q;
  swr_srch_t       srch_q;
  logic [7:0]      sh_q;
  logic [2:0]      bit_q;
  logic [5:0]      rom_q;
  logic [7:0]      cmd_q;
  logic [2:0]      addr_q;
  logic            tx_q;
  logic            match_q;
  logic [7:0]      scr_q [APP_BYTES];
  logic [7:0]      app_q [APP_BYTES];
  logic            locked_q;
  logic [7:0]      tx_byte;
  logic            tx_bit;
  logic            rom_bit;
  logic            byte_done;
  logic [7:0]      rx_byte;
  swr_wr_t         wr_in;
  swr_wr_t         wr_out;
  logic            wr_valid;
  logic            wr_ready;
  logic            wr_push;
  logic            wr_out_valid;

  assign bus_rst = ev.rst_pulse || idle_low;

  swr_line u_line (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .line_i      (line_i),
    .send_zero_i (send_zero),
    .ev_o        (ev),
    .line_oe_n_o (line_oe_n_o),
    .line_o      (line_o),
    .idle_low_o  (idle_low)
  );

  assign wr_in = '{addr: addr_q, data: rx_byte};

  swr_fifo #(
    .WIDTH (3 + FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .flush_i     (1'b0),
    .in_data_i   (wr_in),
    .in_valid_i  (wr_push),
    .in_ready_o  (wr_ready),
    .out_data_o  (wr_out),
    .out_valid_o (wr_out_valid),
    .out_ready_i (1'b1)
  );

  // ==========================================================================
  // Bit source for read slots
  // ==========================================================================
  assign rom_bit  = ROM_ID[rom_q];
  assign rx_byte  = {ev.sampled, sh_q[7:1]};
  assign byte_done = ev.slot && (bit_q == 3'h7);
  assign lock_status_byte_o = locked_q ? STATUS_LOCKED : STATUS_UNLOCKED;
  assign locked_o = locked_q;

  always_comb begin
    tx_byte = STATUS_UNLOCKED;
    if (cmd_q == CMD_READ_STATUS) begin
      tx_byte = lock_status_byte_o;
    end else if (locked_q) begin
      tx_byte = app_q[addr_q];
    end else begin
      tx_byte = scr_q[addr_q];
    end
  end

  always_comb begin
    tx_bit = 1'b1;
    unique case (st_q)
      ST_ROM_TX:  tx_bit = rom_bit;
      ST_SEARCH:  tx_bit = (srch_q == SR_BIT)  ? rom_bit :
                           (srch_q == SR_COMP) ? !rom_bit : 1'b1;
      ST_RD_DATA: tx_bit = tx_byte[bit_q];
      default:    tx_bit = 1'b1;
    endcase
  end

  assign send_zero = tx_q && !tx_bit;

  // ==========================================================================
  // Protocol sequencer
  // ==========================================================================
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_q    <= ST_IDLE;
      srch_q  <= SR_BIT;
      sh_q    <= '0;
      bit_q   <= '0;
      rom_q   <= '0;
      cmd_q   <= '0;
      addr_q  <= '0;
      tx_q    <= 1'b0;
      match_q <= 1'b0;
    end else if (bus_rst) begin
      st_q    <= ST_ROM_CMD;
      bit_q   <= '0;
      rom_q   <= '0;
      tx_q    <= 1'b0;
      srch_q  <= SR_BIT;
      match_q <= 1'b1;
    end else if (ev.slot) begin
      sh_q  <= rx_byte;
      bit_q <= bit_q + 1'b1;
      unique case (st_q)
        ST_IDLE, ST_WAIT: begin
          bit_q <= '0;
        end
        ST_ROM_CMD: begin
          if (byte_done) begin
            unique case (rx_byte)
              CMD_READ_ROM:   begin st_q <= ST_ROM_TX; tx_q <= 1'b1; end
              CMD_MATCH_ROM:  st_q <= ST_MATCH;
              CMD_SKIP_ROM:   st_q <= ST_MEM_CMD;
              CMD_SEARCH_ROM: begin st_q <= ST_SEARCH; tx_q <= 1'b1; end
              default:        st_q <= ST_WAIT;
            endcase
          end
        end
        ST_ROM_TX: begin
          rom_q <= rom_q + 1'b1;
          if (rom_q == 6'h3F) begin
            st_q <= ST_MEM_CMD;
            tx_q <= 1'b0;
          end
        end
        ST_MATCH: begin
          rom_q <= rom_q + 1'b1;
          if (ev.sampled != rom_bit) begin
            match_q <= 1'b0;
          end
          if (rom_q == 6'h3F) begin
            st_q <= (match_q && ev.sampled == rom_bit) ? ST_MEM_CMD : ST_WAIT;
          end
        end
        ST_SEARCH: begin
          bit_q <= '0;
          unique case (srch_q)
            SR_BIT:  srch_q <= SR_COMP;
            SR_COMP: begin srch_q <= SR_PICK; tx_q <= 1'b0; end
            default: begin
              srch_q <= SR_BIT;
              tx_q   <= 1'b1;
              rom_q  <= rom_q + 1'b1;
              if (ev.sampled != rom_bit) begin
                st_q <= ST_WAIT;
                tx_q <= 1'b0;
              end else if (rom_q == 6'h3F) begin
                st_q <= ST_MEM_CMD;
                tx_q <= 1'b0;
              end
            end
          endcase
        end
        ST_MEM_CMD: begin
          if (byte_done) begin
            cmd_q <= rx_byte;
            unique case (rx_byte)
              CMD_WRITE_APP, CMD_READ_APP: st_q <= ST_ADDR;
              CMD_READ_STATUS, CMD_COPY_LOCK: st_q <= ST_KEY;
              default: st_q <= ST_WAIT;
            endcase
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            addr_q <= rx_byte[2:0];
            if (cmd_q == CMD_READ_APP) begin
              st_q <= ST_RD_DATA;
              tx_q <= 1'b1;
            end else begin
              st_q <= ST_WR_DATA;
            end
          end
        end
        ST_WR_DATA: begin
          if (byte_done) begin
            addr_q <= addr_q + 1'b1;
          end
        end
        ST_RD_DATA: begin
          if (byte_done && cmd_q == CMD_READ_APP) begin
            addr_q <= addr_q + 1'b1;
          end
        end
        ST_KEY: begin
          if (byte_done) begin
            if (cmd_q == CMD_READ_STATUS && rx_byte == KEY_STATUS) begin
              st_q <= ST_RD_DATA;
              tx_q <= 1'b1;
            end else begin
              st_q <= ST_WAIT;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Register scratchpad, application register and lock
  // ==========================================================================
  assign wr_valid = (st_q == ST_WR_DATA) && byte_done && !bus_rst;
  assign wr_push  = wr_valid && wr_ready && !locked_q;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      for (int i = 0; i < APP_BYTES; i++) begin
        scr_q[i] <= 8'hFF;
      end
    end else if (wr_out_valid && !locked_q) begin
      scr_q[wr_out.addr] <= wr_out.data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      locked_q <= 1'b0;
      for (int i = 0; i < APP_BYTES; i++) begin
        app_q[i] <= 8'hFF;
      end
    end else if (!bus_rst && st_q == ST_KEY && byte_done && cmd_q == CMD_COPY_LOCK
                 && rx_byte == KEY_COPY_LOCK && !locked_q) begin
      locked_q <= 1'b1;
      for (int i = 0; i < APP_BYTES; i++) begin
        app_q[i] <= scr_q[i];
      end
    end
  end

  for (genvar g = 0; g < APP_BYTES; g++) begin : g_app
    assign app_reg_o[g*8 +: 8] = app_q[g];
  end

endmodule

// file: verification/swr_slave_asserts.sv
module swr_slave_asserts (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        line_i,
  input wire logic        line_o,
  input wire logic        line_oe_n_o,
  input wire logic        locked_o,
  input wire logic [7:0]  lock_status_byte_o,
  input wire logic [63:0] app_reg_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Line history
  // ==========================================================================
  logic [15:0] low_cnt_q;
  logic [15:0] pull_cnt_q;
  logic        rst_rise;

  always_ff @(posedge clock_i) begin
    if (reset_i || line_i) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'hFFFF) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i || line_oe_n_o) begin
      pull_cnt_q <= 16'h0000;
    end else if (pull_cnt_q != 16'hFFFF) begin
      pull_cnt_q <= pull_cnt_q + 16'h0001;
    end
  end

  // End of a bus reset pulse of at least 480 us
  assign rst_rise = line_i && (low_cnt_q >= 16'h12C0);

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_status_lock_map: assert property (lock_status_byte_o == (locked_o ? 8'hFC : 8'hFF))
    else $error("status byte does not follow the lock");
  a_lock_sticky: assert property (locked_o |=> locked_o)
    else $error("lock was lost");
  a_app_frozen: assert property (locked_o |=> $stable(app_reg_o))
    else $error("locked register changed");
  a_app_copy_once: assert property ($changed(app_reg_o) |-> $rose(locked_o))
    else $error("register changed without copy and lock");
  a_pull_drives_low: assert property (!line_oe_n_o |-> !line_o)
    else $error("enabled line output not low");
  a_presence_wait: assert property (rst_rise |-> ##250 line_oe_n_o)
    else $error("presence started too early");
  a_presence_start: assert property (rst_rise |-> ##[298:303] !line_oe_n_o)
    else $error("presence pulse missing");
  a_pull_length: assert property ($rose(line_oe_n_o) |->
    pull_cnt_q inside {[16'h0127:16'h0131], [16'h04AB:16'h04B5]})
    else $error("pull low has wrong length");
  a_long_low_free: assert property (low_cnt_q > 16'h0514 |-> line_oe_n_o)
    else $error("device pulls during long low");

  c_bus_reset: cover property (rst_rise);
  c_lock: cover property ($rose(locked_o));
  c_read_zero: cover property ($rose(line_oe_n_o) && pull_cnt_q < 16'h0190);
endmodule

bind swr_slave swr_slave_asserts u_swr_slave_asserts (
  .clock_i            (clock_i),
  .reset_i            (reset_i),
  .line_i             (line_i),
  .line_o             (line_o),
  .line_oe_n_o        (line_oe_n_o),
  .locked_o           (locked_o),
  .lock_status_byte_o (lock_status_byte_o),
  .app_reg_o          (app_reg_o)
);

// file: verification/swr_master_model.sv
module swr_master_model (
  input  wire logic       clock_i,
  input  wire logic       line_i,
  output logic            pull_low_o,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned SLOT_CYC = 315;
  localparam int unsigned LOW1_CYC = 20;
  localparam int unsigned LOW0_CYC = 305;
  localparam int unsigned SMP_CYC  = 100;
  localparam int unsigned RSTL_CYC = 4810;
  localparam int unsigned RSTH_CYC = 1550;

  initial begin
    pull_low_o = 1'b0;
    rd_data_o = 8'h00;
    rd_valid_o = 1'b0;
  end

  task automatic hold(input int unsigned n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic bus_reset(output logic seen);
    seen = 1'b0;
    pull_low_o = 1'b1;
    hold(RSTL_CYC);
    pull_low_o = 1'b0;
    repeat (RSTH_CYC) begin
      @(negedge clock_i);
      if (line_i === 1'b0) begin
        seen = 1'b1;
      end
    end
  endtask

  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      pull_low_o = 1'b1;
      hold(v[i] ? LOW1_CYC : LOW0_CYC);
      pull_low_o = 1'b0;
      hold(v[i] ? SLOT_CYC - LOW1_CYC : SLOT_CYC - LOW0_CYC);
    end
  endtask

  task automatic read_byte();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      pull_low_o = 1'b1;
      hold(LOW1_CYC);
      pull_low_o = 1'b0;
      hold(SMP_CYC - LOW1_CYC);
      v[i] = line_i;
      hold(SLOT_CYC - SMP_CYC);
    end
    rd_data_o = v;
    rd_valid_o = 1'b1;
    hold(1);
    rd_valid_o = 1'b0;
  endtask
endmodule

// file: verification/swr_slave_tb.sv
module swr_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import swr_pkg::*;

  localparam int unsigned TIMEOUT_CYC = 99000;

  logic        clock_i;
  logic        reset_i;
  logic        line_w;
  logic        line_o;
  logic        line_oe_n_o;
  logic        locked_o;
  logic [7:0]  lock_status_byte_o;
  logic [63:0] app_reg_o;
  logic        pull_low;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [7:0]  exp_q[$];
  logic [31:0] rng_q = 32'h0000FBCF;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;

  // Open-drain wire with pull-up
  assign line_w = (pull_low === 1'b1) ? 1'b0 : ((line_oe_n_o === 1'b0) ? line_o : 1'b1);

  swr_slave u_swr_slave (
    .clock_i            (clock_i),
    .reset_i            (reset_i),
    .line_i             (line_w),
    .line_o             (line_o),
    .line_oe_n_o        (line_oe_n_o),
    .locked_o           (locked_o),
    .lock_status_byte_o (lock_status_byte_o),
    .app_reg_o          (app_reg_o)
  );

  swr_master_model u_swr_master_model (
    .clock_i    (clock_i),
    .line_i     (line_w),
    .pull_low_o (pull_low),
    .rd_data_o  (rd_data),
    .rd_valid_o (rd_valid)
  );

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [7:0] next_rand();
    rng_q ^= rng_q << 13;
    rng_q ^= rng_q >> 17;
    rng_q ^= rng_q << 5;
    return rng_q[7:0];
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("counts: checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] b);
    u_swr_master_model.write_byte(b);
  endtask

  task automatic get(input logic [7:0] exp);
    exp_q.push_back(exp);
    u_swr_master_model.read_byte();
  endtask

  // Reset, presence, skip of identity, then a memory command
  task automatic open(input logic [7:0] mem_cmd);
    logic pres;
    u_swr_master_model.bus_reset(pres);
    check(64'(pres), 64'h1);
    put(CMD_SKIP_ROM);
    put(mem_cmd);
  endtask

  always @(posedge clock_i) begin
    if (rd_valid === 1'b1) begin
      check(64'(rd_data), 64'(exp_q.pop_front()));
    end
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == TIMEOUT_CYC) begin
      errors++;
      complete_run();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [63:0] app_exp;
    reset_i = 1'b1;
    repeat (10) @(negedge clock_i);
    reset_i = 1'b0;
    d0 = next_rand();
    d1 = next_rand();
    app_exp = {d0, 48'hFFFF_FFFF_FFFF, d1};
    open(CMD_WRITE_APP);
    put(8'h07);
    put(d0);
    put(d1);
    check(app_reg_o, 64'hFFFF_FFFF_FFFF_FFFF);
    $display("test 1 write with wrap done");
    open(CMD_READ_APP);
    put(8'h07);
    get(d0);
    get(d1);
    $display("test 2 read with wrap done");
    open(CMD_READ_STATUS);
    put(KEY_STATUS);
    get(STATUS_UNLOCKED);
    $display("test 3 status unlocked done");
    open(CMD_COPY_LOCK);
    open(CMD_COPY_LOCK);
    check(64'(locked_o), 64'h0);
    put(KEY_COPY_LOCK);
    u_swr_master_model.hold(10);
    check(64'(locked_o), 64'h1);
    check(64'(lock_status_byte_o), 64'(STATUS_LOCKED));
    check(app_reg_o, app_exp);
    $display("test 4 cancel then lock done");
    open(CMD_WRITE_APP);
    put(8'h00);
    put(next_rand());
    u_swr_master_model.hold(10);
    check(app_reg_o, app_exp);
    check(64'(locked_o), 64'h1);
    $display("test 5 write after lock done");
    complete_run();
  end
endmodule
